// *** hdl/ucr_endpoint_regs.sv ***
// Notes on behaviour
// RQ1 - Enable bit 5 passes the wake-up event to the interrupt line.
// RQ2 - Enable bit 4 passes end-of-reset; enable register resets to 10h.
// RQ3 - Enable bit 3 passes the start-of-frame event to the interrupt line.
// RQ4 - Enable bit 0 passes the suspend event to the interrupt line.
// RQ5 - Reserved bits read zero; software writes only zeros there.
// RQ6 - Address register bit 7 switches address filtering on or off.
// RQ7 - Seven-bit device address is zero after reset and every bus reset.
// RQ8 - Firmware loads the address delivered by a set-address request.
// RQ9 - Endpoint index bits 3-0 pick which endpoint indexed accesses reach.
// RQ10 - Software programs the endpoint index only with values 0 to 5.
// RQ11 - Control bit 7 enables the selected endpoint.
// RQ12 - Endpoint 0 comes up enabled after hardware reset and bus reset.
// RQ13 - Toggle bit is read-only: DATA0 sets it, DATA1 clears it.
// RQ14 - Control bit 2 selects IN when one, OUT when zero.
// RQ15 - Direction bit is ignored for control endpoints.
// RQ16 - Type field: 00 control, 01 isochronous, 10 bulk, 11 interrupt.
// RQ17 - Software always configures endpoint 0 as a control endpoint.
// RQ18 - A start-of-frame token sets its flag; software clears it.
// RQ19 - End of bus reset sets its flag; software clears it.
// RQ20 - Non-idle activity while suspended sets the wake-up flag.
// RQ21 - Endpoint control resets to 80h for endpoint 0, 00h otherwise.
// RQ22 - With filtering on, only tokens to the programmed address are answered.
// RQ23 - Interrupt stands while any flag and its enable are both set.
`timescale 1ns/1ps
module ucr_endpoint_regs
    import ucr_pkg::*;
#(
    parameter int NUM_EP = NUM_EP_DEF
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Serial engine side.
    input  wire ucr_events_s              evt,
    input  wire ucr_toggle_s              tgl,
    input  wire logic                     tokenValid,
    input  wire logic [6:0]               tokenAddr,
    output logic                          tokenMatch,
    // Configuration and interrupt.
    output logic                          usbIrq,
    output logic [3:0]                    epIndex,
    output logic                          addrFilterOn,
    output logic [6:0]                    deviceAddr,
    output ucr_ep_cfg_s [NUM_EP-1:0]      epCfg
);

    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    logic [7:0] regIdx;
    logic       aligned;
    logic       hitFlags;
    logic       hitIrqEn;
    logic       hitAddr;
    logic       hitSel;
    logic       hitCtl;
    logic       mapped;
    logic       setupPhase;
    logic       accessPhase;
    logic       wrLow;
    logic [7:0] wrByte;
    logic [7:0] irqEn;
    logic [7:0] irqFlags;
    logic [7:0] next_flags;
    logic [7:0] setVec;
    logic [7:0] devAddrReg;
    logic [7:0] rdByte;
    logic [7:0] rdEp;
    logic       epSelValid;
    logic [7:0] epRegs [NUM_EP];

    // The index sits above the two byte bits; misaligned addresses miss.
    assign regIdx      = paddr[ADDR_W-1:2];
    assign aligned     = (paddr[1:0] == 2'b00);
    assign hitFlags    = aligned && (regIdx == IDX_IRQ_FLAGS);
    assign hitIrqEn    = aligned && (regIdx == IDX_IRQ_EN);
    assign hitAddr     = aligned && (regIdx == IDX_DEV_ADDR);
    assign hitSel      = aligned && (regIdx == IDX_EP_SEL);
    assign hitCtl      = aligned && (regIdx == IDX_EP_CTRL);
    assign mapped      = hitFlags || hitIrqEn || hitAddr || hitSel || hitCtl;
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrByte      = pwdata[7:0];

    // Only lane 0 carries register data; an empty strobe writes nothing.
    assign wrLow = accessPhase && pwrite && pstrb[0] && mapped;

    // Zero wait states; unmapped accesses complete with an error.
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !mapped;

    // ----------------------------------------------------------------
    // Global interrupt enables.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irqEn <= IRQ_EN_RST; // RQ2
        end else if (wrLow && hitIrqEn) begin
            irqEn <= wrByte & IRQ_MASK; // RQ1 RQ2 RQ3 RQ4 RQ5
        end
    end

    // ----------------------------------------------------------------
    // Event flags: hardware sets, software clears by writing a zero.
    // A set arriving in the clearing cycle wins so no event is lost.
    // ----------------------------------------------------------------
    always_comb begin
        setVec              = 8'h00;
        setVec[BIT_SOF]     = evt.sofSeen; // RQ18
        setVec[BIT_RST_END] = evt.resetEnd; // RQ19
        setVec[BIT_WAKE]    = evt.suspended && evt.wakeActivity; // RQ20
        setVec[BIT_SUSP]    = evt.suspendSeen;
        next_flags          = irqFlags;
        if (wrLow && hitFlags) begin
            next_flags = irqFlags & wrByte;
        end
        next_flags = (next_flags | setVec) & IRQ_MASK; // RQ5
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqFlags <= IRQ_FLAG_RST;
        end else begin
            irqFlags <= next_flags;
        end
    end

    // Registered so the line is glitch free; it trails the flags by one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            usbIrq <= 1'b0;
        end else begin
            usbIrq <= |(irqFlags & irqEn); // RQ1 RQ2 RQ3 RQ4 RQ23
        end
    end

    // ----------------------------------------------------------------
    // Device address; bus reset clears the address but keeps the filter.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            devAddrReg <= DEV_ADDR_RST; // RQ7
        end else if (evt.busReset) begin
            devAddrReg[ADDR_HI:0] <= DEV_FIELD_RST; // RQ7
        end else if (wrLow && hitAddr) begin
            devAddrReg <= wrByte; // RQ6
        end
    end

    assign addrFilterOn = devAddrReg[BIT_FILTER]; // RQ6
    assign deviceAddr   = devAddrReg[ADDR_HI:0];

    // With the filter off every token is ours, as during enumeration.
    assign tokenMatch = tokenValid && (!addrFilterOn || tokenAddr == deviceAddr); // RQ22

    // ----------------------------------------------------------------
    // Endpoint index select.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            epIndex <= EP_SEL_RST;
        end else if (wrLow && hitSel) begin
            epIndex <= wrByte[EPIDX_HI:0]; // RQ9
        end
    end

    // Indexes above the last endpoint reach nothing: reads zero, writes lost.
    assign epSelValid = (32'(epIndex) < NUM_EP); // RQ10

    // ----------------------------------------------------------------
    // Per-endpoint control registers and their decoded view.
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
        logic selHere;
        logic tglHere;

        assign selHere = (epIndex == 4'(i)); // RQ9
        assign tglHere = tgl.valid && (tgl.ep == 4'(i));

        ucr_ep_ctrl #(
            .RST_VAL (i == 0 ? EPCTL_RST_EP0 : EPCTL_RST_OTH) // RQ21
        ) u_ep (
            .clk       (clk),
            .rst       (rst),
            .busReset  (evt.busReset), // RQ12
            .wrEn      (wrLow && hitCtl && selHere), // RQ9 RQ11
            .wrData    (wrByte),
            .toggleSet (tglHere && !tgl.data1), // RQ13
            .toggleClr (tglHere && tgl.data1), // RQ13
            .ctrlReg   (epRegs[i])
        );

        // Control endpoints have no direction, so it is forced to OUT.
        assign epCfg[i].on    = epRegs[i][BIT_EP_ON]; // RQ11
        assign epCfg[i].xfer  = ucr_xfer_e'(epRegs[i][TYPE_HI:TYPE_LO]); // RQ16
        assign epCfg[i].dirIn = epRegs[i][BIT_DIR]
                                && (epCfg[i].xfer != XFER_CTRL); // RQ14 RQ15

        AST_CTRL_NO_DIR: assert property (@(posedge clk) disable iff (rst) // RQ15
            (epRegs[i][TYPE_HI:TYPE_LO] == 2'b00) |-> !epCfg[i].dirIn)
            else $error("control endpoint shows a direction");
    end

    // ----------------------------------------------------------------
    // Read path: data is captured in the setup cycle, valid in access.
    // ----------------------------------------------------------------
    always_comb begin
        rdEp = 8'h00;
        for (int i = 0; i < NUM_EP; i++) begin
            if (epIndex == 4'(i)) begin
                rdEp = epRegs[i]; // RQ9
            end
        end
    end

    always_comb begin
        rdByte = 8'h00;
        if (hitFlags) begin
            rdByte = irqFlags;
        end else if (hitIrqEn) begin
            rdByte = irqEn;
        end else if (hitAddr) begin
            rdByte = devAddrReg;
        end else if (hitSel) begin
            rdByte = {4'h0, epIndex}; // RQ5
        end else if (hitCtl && epSelValid) begin
            rdByte = rdEp;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= RDATA_RST;
        end else if (setupPhase) begin
            prdata <= {24'h00_0000, rdByte}; // RQ5
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    AST_EN_RESET_VALUE: assert property (@(posedge clk) disable iff (rst) // RQ2
        $fell(rst) |-> (irqEn == 8'h10))
        else $error("interrupt enable did not reset to 10h");

    AST_WAKE_GATED: assert property (@(posedge clk) disable iff (rst) // RQ1
        (irqFlags == 8'h20 && !irqEn[BIT_WAKE]) |=> !usbIrq)
        else $error("masked wake-up event raised the interrupt");

    AST_SOF_TO_IRQ: assert property (@(posedge clk) disable iff (rst) // RQ3
        (evt.sofSeen && irqEn[BIT_SOF] && !(wrLow && (hitIrqEn || hitFlags)))
        |=> irqFlags[BIT_SOF] ##1 usbIrq)
        else $error("start-of-frame did not reach the interrupt in two cycles");

    AST_SUSP_GATED: assert property (@(posedge clk) disable iff (rst) // RQ4
        (irqFlags == 8'h01 && !irqEn[BIT_SUSP]) |=> !usbIrq)
        else $error("masked suspend event raised the interrupt");

    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst) // RQ5
        (accessPhase && !pwrite && hitIrqEn) |-> (prdata[7:6] == 2'b00 && prdata[2:1] == 2'b00))
        else $error("reserved enable bits read nonzero");

    AST_ADDR_BUS_RESET: assert property (@(posedge clk) disable iff (rst) // RQ7
        evt.busReset |=> (deviceAddr == 7'h00))
        else $error("device address not cleared by bus reset");

    AST_EP_SELECT_READ: assert property (@(posedge clk) disable iff (rst) // RQ9
        (setupPhase && hitCtl && epIndex == 4'h0) |=> (prdata[7:0] == $past(epRegs[0])))
        else $error("control read did not return endpoint 0");

    AST_EP0_ON_BUS_RESET: assert property (@(posedge clk) disable iff (rst) // RQ12
        evt.busReset |=> (epCfg[0].on && epRegs[0] == 8'h80))
        else $error("endpoint 0 not enabled after bus reset");

    AST_RESET_END_FLAG: assert property (@(posedge clk) disable iff (rst) // RQ19
        evt.resetEnd |=> irqFlags[BIT_RST_END])
        else $error("end-of-reset flag not set");

    AST_WAKE_ONLY_SUSPENDED: assert property (@(posedge clk) disable iff (rst) // RQ20
        ($rose(irqFlags[BIT_WAKE])) |-> $past(evt.suspended && evt.wakeActivity))
        else $error("wake-up flag set while not suspended");

    AST_FILTER_BLOCKS: assert property (@(posedge clk) disable iff (rst) // RQ22
        (addrFilterOn && tokenAddr != deviceAddr) |-> !tokenMatch)
        else $error("token to a foreign address accepted");

    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst) // RQ23
        (usbIrq != $past(|(irqFlags & irqEn))) |-> $past(rst))
        else $error("interrupt does not follow flags and enables");

endmodule

// *** hdl/ucr_ep_ctrl.sv ***
`timescale 1ns/1ps
module ucr_ep_ctrl
    import ucr_pkg::*;
#(
    parameter logic [7:0] RST_VAL = EPCTL_RST_OTH
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       busReset,
    // Software write port.
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    // Hardware toggle updates.
    input  wire logic       toggleSet,
    input  wire logic       toggleClr,
    // Register contents.
    output logic [7:0]      ctrlReg
);

    logic [7:0] next_ctrl;

    // ----------------------------------------------------------------
    // Next value: software owns enable, direction and type; the toggle
    // bit belongs to hardware alone, and reserved bits never load.
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrlReg;
        if (wrEn) begin
            next_ctrl = (ctrlReg & ~EPCTL_WR_MASK) | (wrData & EPCTL_WR_MASK); // RQ5 RQ11 RQ14 RQ16
        end
        if (toggleSet) begin
            next_ctrl[BIT_TOGGLE] = 1'b1; // RQ13
        end else if (toggleClr) begin
            next_ctrl[BIT_TOGGLE] = 1'b0; // RQ13
        end
    end

    // Bus reset restores the power-up value, so endpoint 0 comes back on.
    always_ff @(posedge clk) begin
        if (rst || busReset) begin
            ctrlReg <= RST_VAL; // RQ12 RQ21
        end else begin
            ctrlReg <= next_ctrl;
        end
    end

    // A DATA0 acceptance must leave the toggle bit set.
    AST_TOGGLE_SET: assert property (@(posedge clk) disable iff (rst) // RQ13
        (toggleSet && !busReset) |=> ctrlReg[BIT_TOGGLE])
        else $error("toggle bit not set after DATA0");

endmodule

// *** hdl/ucr_pkg.sv ***
package ucr_pkg;

    // ----------------------------------------------------------------
    // Register map: printed offsets are indexes, byte address = 4 * index.
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 10;
    localparam int          NUM_EP_DEF    = 6;
    localparam logic [7:0]  IDX_IRQ_FLAGS = 8'hbd;
    localparam logic [7:0]  IDX_IRQ_EN    = 8'hbe;
    localparam logic [7:0]  IDX_DEV_ADDR  = 8'hc6;
    localparam logic [7:0]  IDX_EP_SEL    = 8'hc7;
    localparam logic [7:0]  IDX_EP_CTRL   = 8'hd4;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values.
    // ----------------------------------------------------------------
    localparam int          BIT_WAKE      = 5;
    localparam int          BIT_RST_END   = 4;
    localparam int          BIT_SOF       = 3;
    localparam int          BIT_SUSP      = 0;
    localparam int          BIT_FILTER    = 7;
    localparam int          BIT_EP_ON     = 7;
    localparam int          BIT_TOGGLE    = 3;
    localparam int          BIT_DIR       = 2;
    localparam int          TYPE_HI       = 1;
    localparam int          TYPE_LO       = 0;
    localparam int          ADDR_HI       = 6;
    localparam int          EPIDX_HI      = 3;
    localparam logic [7:0]  IRQ_MASK      = 8'h39;
    localparam logic [7:0]  IRQ_EN_RST    = 8'h10;
    localparam logic [7:0]  IRQ_FLAG_RST  = 8'h00;
    localparam logic [7:0]  DEV_ADDR_RST  = 8'h00;
    localparam logic [6:0]  DEV_FIELD_RST = 7'h00;
    localparam logic [3:0]  EP_SEL_RST    = 4'h0;
    localparam logic [7:0]  EPCTL_WR_MASK = 8'h87;
    localparam logic [7:0]  EPCTL_RST_EP0 = 8'h80;
    localparam logic [7:0]  EPCTL_RST_OTH = 8'h00;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // Transfer type encoding of the endpoint control type field.
    typedef enum logic [1:0] {
        XFER_CTRL = 2'b00,
        XFER_ISO  = 2'b01,
        XFER_BULK = 2'b10,
        XFER_INTR = 2'b11
    } ucr_xfer_e;

    // Bus events reported by the serial engine, same clock domain.
    typedef struct packed {
        logic sofSeen;
        logic resetEnd;
        logic wakeActivity;
        logic suspendSeen;
        logic busReset;
        logic suspended;
    } ucr_events_s;

    // Accepted data packet report used for the toggle bit.
    typedef struct packed {
        logic       valid;
        logic [3:0] ep;
        logic       data1;
    } ucr_toggle_s;

    // Decoded configuration of one endpoint.
    typedef struct packed {
        logic      on;
        logic      dirIn;
        ucr_xfer_e xfer;
    } ucr_ep_cfg_s;

endpackage

// *** verif/ucr_endpoint_regs_tb_top.sv ***
`timescale 1ns/1ps
module ucr_endpoint_regs_tb_top
    import ucr_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and instances.
    // ----------------------------------------------------------------
    logic                        clk = 1'b0;
    logic                        rst;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [ADDR_W-1:0]           paddr;
    logic [31:0]                 pwdata;
    logic [3:0]                  pstrb;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    ucr_events_s                 evt;
    ucr_toggle_s                 tgl;
    logic                        tokenValid;
    logic [6:0]                  tokenAddr;
    logic                        tokenMatch;
    logic                        usbIrq;
    logic [3:0]                  epIndex;
    logic                        addrFilterOn;
    logic [6:0]                  deviceAddr;
    ucr_ep_cfg_s [NUM_EP_DEF-1:0] epCfg;
    int                          failCount = 0;
    int                          samplesChecked = 0;
    int                          cycles = 0;

    ucr_endpoint_regs #(.NUM_EP(NUM_EP_DEF)) i_ucr_endpoint_regs (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt(evt), .tgl(tgl),
        .tokenValid(tokenValid), .tokenAddr(tokenAddr), .tokenMatch(tokenMatch),
        .usbIrq(usbIrq), .epIndex(epIndex), .addrFilterOn(addrFilterOn),
        .deviceAddr(deviceAddr), .epCfg(epCfg));

    ucr_sie_model i_ucr_sie_model (
        .clk(clk), .tokenMatch(tokenMatch), .evt(evt), .tgl(tgl),
        .tokenValid(tokenValid), .tokenAddr(tokenAddr));

    // 250 MHz clock.
    always #2 clk = ~clk;

    // Hang guard: the tests need well under a thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            endSim();
        end
    end

    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    // Closing report, the single end of the run.
    task automatic endSim();
        $display("checks %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Case-equal comparison so an unknown never counts as a match.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wdata};
        pstrb <= wr ? 4'h1 : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] data);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, data, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 8'h00, rd, err);
        check(rd, {24'h00_0000, exp});
    endtask

    // Let registered outputs settle, then sample mid-cycle.
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // Test sequence.
    // ----------------------------------------------------------------
    localparam int         FLAG_BIT [4] = '{3, 4, 5, 0};
    localparam logic [5:0] EVT_MASK [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    localparam logic [7:0] EP_VAL   [6] = '{8'h80, 8'h80, 8'h85, 8'h06, 8'h83, 8'h84};

    initial begin
        logic [31:0] rd;
        logic        err;
        logic        hit;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values of the enable, address, select and endpoint 0 control registers.
        rd_chk(IDX_IRQ_EN, 8'h10);
        rd_chk(IDX_DEV_ADDR, 8'h00);
        rd_chk(IDX_EP_SEL, 8'h00);
        rd_chk(IDX_EP_CTRL, 8'h80);
        check({28'h000_0000, epCfg[0]}, 32'h0000_0008);
        // Each event sets its flag; the interrupt follows only its enable.
        i_ucr_sie_model.set_suspended(1'b1);
        for (int i = 0; i < 4; i++) begin
            wr_reg(IDX_IRQ_EN, 8'h00);
            i_ucr_sie_model.pulse_event(EVT_MASK[i]);
            wait_n(3);
            check({31'h0, usbIrq}, 32'h0);
            rd_chk(IDX_IRQ_FLAGS, 8'h01 << FLAG_BIT[i]);
            wr_reg(IDX_IRQ_EN, 8'h01 << FLAG_BIT[i]);
            wait_n(2);
            check({31'h0, usbIrq}, 32'h1);
            wr_reg(IDX_IRQ_FLAGS, 8'h00);
            wait_n(2);
            check({31'h0, usbIrq}, 32'h0);
        end
        // Bus activity outside suspend is no wake-up.
        i_ucr_sie_model.set_suspended(1'b0);
        i_ucr_sie_model.pulse_event(6'h08);
        rd_chk(IDX_IRQ_FLAGS, 8'h00);
        // Ones written into reserved places read back as zero.
        wr_reg(IDX_IRQ_EN, 8'hff);
        rd_chk(IDX_IRQ_EN, 8'h39);
        // An enabled start-of-frame reaches the line without software help.
        i_ucr_sie_model.pulse_event(6'h20);
        wait_n(2);
        check({31'h0, usbIrq}, 32'h1);
        wr_reg(IDX_IRQ_FLAGS, 8'h00);
        wait_n(2);
        check({31'h0, usbIrq}, 32'h0);
        // Address filter on and off.
        wr_reg(IDX_DEV_ADDR, 8'haa);
        rd_chk(IDX_DEV_ADDR, 8'haa);
        check({24'h00_0000, addrFilterOn, deviceAddr}, 32'h0000_00aa);
        i_ucr_sie_model.send_token(7'h2a, hit);
        check({31'h0, hit}, 32'h1);
        i_ucr_sie_model.send_token(7'h2b, hit);
        check({31'h0, hit}, 32'h0);
        wr_reg(IDX_DEV_ADDR, 8'h2a);
        i_ucr_sie_model.send_token(7'h55, hit);
        check({31'h0, hit}, 32'h1);
        wr_reg(IDX_DEV_ADDR, 8'haa);
        // Configure every endpoint, endpoint 0 as control, then read each back.
        for (int e = 0; e < 6; e++) begin
            wr_reg(IDX_EP_SEL, 8'(e));
            wr_reg(IDX_EP_CTRL, EP_VAL[e]);
        end
        for (int e = 0; e < 6; e++) begin
            wr_reg(IDX_EP_SEL, 8'(e));
            rd_chk(IDX_EP_SEL, 8'(e));
            check({28'h000_0000, epIndex}, 32'(e));
            rd_chk(IDX_EP_CTRL, EP_VAL[e]);
            check({28'h0, epCfg[e]}, {28'h0, EP_VAL[e][7],
                  EP_VAL[e][2] & (EP_VAL[e][1:0] != 2'b00), EP_VAL[e][1:0]});
        end
        // Toggle bit follows accepted packets and ignores writes.
        wr_reg(IDX_EP_SEL, 8'h02);
        i_ucr_sie_model.send_data(4'h2, 1'b0);
        rd_chk(IDX_EP_CTRL, 8'h8d);
        i_ucr_sie_model.send_data(4'h2, 1'b1);
        rd_chk(IDX_EP_CTRL, 8'h85);
        wr_reg(IDX_EP_CTRL, 8'hff);
        rd_chk(IDX_EP_CTRL, 8'h87);
        // Bus reset clears the address and restores endpoint control.
        i_ucr_sie_model.pulse_event(6'h02);
        rd_chk(IDX_DEV_ADDR, 8'h80);
        check({24'h00_0000, addrFilterOn, deviceAddr}, 32'h0000_0080);
        rd_chk(IDX_EP_CTRL, 8'h00);
        wr_reg(IDX_EP_SEL, 8'h00);
        rd_chk(IDX_EP_CTRL, 8'h80);
        // Unmapped place: error response and zero data.
        apb(1'b0, 8'h00, 8'h00, rd, err);
        check(rd, 32'h0000_0000);
        check({31'h0, err}, 32'h1);
        check({31'h0, pready}, 32'h1);
        endSim();
    end
endmodule

// *** verif/ucr_sie_model.sv ***
`timescale 1ns/1ps
module ucr_sie_model
    import ucr_pkg::*;
(
    // Clock and observed match.
    input  wire logic       clk,
    input  wire logic       tokenMatch,
    // Serial engine outputs.
    output ucr_events_s     evt,
    output ucr_toggle_s     tgl,
    output logic            tokenValid,
    output logic [6:0]      tokenAddr
);
    // ----------------------------------------------------------------
    // Bus-side stimulus, one task per kind of traffic.
    // ----------------------------------------------------------------
    // Idle levels at time zero.
    initial begin
        evt = '0;
        tgl = '0;
        tokenValid = 1'b0;
        tokenAddr = 7'h00;
    end

    // One-cycle pulse on the masked event lines.
    task automatic pulse_event(input logic [5:0] mask);
        @(posedge clk);
        evt <= evt | mask;
        @(posedge clk);
        evt <= evt & ~mask;
    endtask

    // The suspended line is a level, held until changed.
    task automatic set_suspended(input logic v);
        @(posedge clk);
        evt.suspended <= v;
    endtask

    // Accepted data packet; fields are scrambled once valid drops.
    task automatic send_data(input logic [3:0] ep, input logic d1);
        @(posedge clk);
        tgl <= '{valid: 1'b1, ep: ep, data1: d1};
        @(posedge clk);
        tgl <= '{valid: 1'b0, ep: ~ep, data1: ~d1};
    endtask

    // Token for one cycle; the match is taken mid-cycle when settled.
    task automatic send_token(input logic [6:0] addr, output logic hit);
        @(posedge clk);
        tokenValid <= 1'b1;
        tokenAddr <= addr;
        @(negedge clk);
        hit = tokenMatch;
        @(posedge clk);
        tokenValid <= 1'b0;
        tokenAddr <= ~addr;
    endtask
endmodule
